//--- thermal_pkg.sv
// Constants and types shared by the thermal clock throttle block
package thermal_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] IRQ_CFG_ADDR = 4'h8;
	localparam logic [3:0] EVENT_ADDR = 4'hc;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_DEMAND_BIT = 4;
	localparam int CTRL_DUTY_LSB = 1;
	localparam int CTRL_DUTY_MSB = 3;
	localparam int CTRL_AUTO_BIT = 0;
	localparam int IRQ_RISE_BIT = 0;
	localparam int IRQ_FALL_BIT = 1;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [1:0] IRQ_CFG_RESET = 2'h0;
	localparam logic [2:0] AUTO_DUTY = 3'h3;
	localparam int SLOT_CYCLES = 4;
	localparam int HYST_CYCLES = 16;
	localparam int BUS_WAIT_CYCLES = 1;

	typedef enum logic [2:0] {
		THR_IDLE = 3'b001,
		THR_RUN = 3'b010,
		THR_STOP = 3'b100
	} thr_state_e;

endpackage

//--- duty_modulator.sv
// Clock gate modulator: k eighths of each period with clocks running
`timescale 1ns/1ps
module duty_modulator
	import thermal_pkg::*;
#(
	parameter int SLOTS = SLOT_CYCLES
) (
	input wire logic clk, // Core clock
	input wire logic rstn, // Async reset, active low
	input wire logic active, // Throttling requested
	input wire logic [2:0] duty, // On eighths, 1..7
	output logic clk_run, // Clock gate enable
	output logic period_end // Last cycle of a period
);
	localparam int CW = $clog2(SLOTS * 8);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [2:0] eighth;
	logic [2:0] duty_eff;

	assign cnt_next = (!active || cnt_reg == CW'(SLOTS * 8 - 1)) ? '0 : cnt_reg + 1'b1;
	assign eighth = 3'(cnt_reg / CW'(SLOTS));
	// Reserved zero treated as one eighth
	assign duty_eff = (duty == 3'h0) ? 3'h1 : duty;
	assign period_end = active && (cnt_reg == CW'(SLOTS * 8 - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// R20: k eighths running
	assign clk_run = !active || (eighth < duty_eff);

	// ****************************************
	// Checks
	// ****************************************
	property p_idle_runs;
		@(posedge clk) disable iff (!rstn) !active |-> clk_run;
	endproperty
	a_idle_runs: assert property (p_idle_runs) else $error("clock gated while idle"); // R1

	property p_first_slot_runs;
		@(posedge clk) disable iff (!rstn) (active && cnt_reg == '0) |-> clk_run;
	endproperty
	a_first_slot_runs: assert property (p_first_slot_runs) else $error("first eighth not running"); // R20

	property p_last_slot_stops;
		@(posedge clk) disable iff (!rstn) period_end |-> !clk_run;
	endproperty
	a_last_slot_stops: assert property (p_last_slot_stops) else $error("last eighth not stopped"); // R20

endmodule // duty_modulator

//--- thermal_clock_throttle.sv
// Thermal monitor: throttle control, alert, trip latch and Avalon registers
// Contract
// R1: Active throttle circuit stops and restarts core clocks at selected duty.
// R2: Automatic mode activates throttling only when over-temperature is flagged.
// R3: Firmware must enable automatic mode; disabled is out of spec.
// R4: Automatic throttling uses fixed part-specific duty, thirty to fifty percent.
// R5: Automatic duty is a constant no software write changes.
// R6: Over-temperature cleared ends modulation and deactivates throttling.
// R7: Hysteresis prevents rapid toggling near trip point.
// R8: Control bit 4 set activates throttling immediately regardless of temperature.
// R9: On-demand duty from control bits 3:1, 12.5 to 87.5 percent.
// R10: Demand with auto enabled and hot uses automatic duty.
// R11: Alert output low while die at thermal limit.
// R12: Throttling stays active while alert asserted and auto enabled.
// R13: Trip threshold fixed in hardware, not software visible.
// R14: Snoops and interrupt latching continue during throttling.
// R15: Interrupt selectable on alert assertion and deassertion.
// R16: Catastrophic temperature shuts down and asserts trip output.
// R17: Trip output latched until reset.
// R18: Trip independent of processor activity, no bus transaction.
// R19: Platform removes core supply after trip within limit.
// R20: Duty value k gives k eighths running; zero reserved.
// R21: Clearing demand ends throttling within one period unless auto holds.
// R22: Reset clears demand bit and duty field; circuit inactive.
`timescale 1ns/1ps
module thermal_clock_throttle
	import thermal_pkg::*;
#(
	parameter int SLOTS = SLOT_CYCLES, // Cycles per eighth
	parameter int HYST = HYST_CYCLES // Cool cycles before release
) (
	input wire logic clk, // Core clock, 250 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic hot_in, // Sensor: near limit
	input wire logic critical_in, // Sensor: catastrophic
	input wire logic [3:0] avs_address, // Byte address
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	output logic core_clk_en, // Core clock gate enable
	output logic thermal_limit_alert_n, // Alert, active low
	output logic thermal_trip_n, // Trip, active low, latched
	output logic shutdown, // Core shutdown request
	output logic thermal_irq, // Alert change interrupt
	output logic clock_throttle_circuit // Throttle active
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic hot_m_reg, hot_s_reg, crit_m_reg, crit_s_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hot_m_reg <= 1'b0;
			hot_s_reg <= 1'b0;
			crit_m_reg <= 1'b0;
			crit_s_reg <= 1'b0;
		end else begin
			hot_m_reg <= hot_in;
			hot_s_reg <= hot_m_reg;
			crit_m_reg <= critical_in;
			crit_s_reg <= crit_m_reg;
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	logic [4:0] ctrl_reg;
	logic [1:0] irq_cfg_reg;
	logic [1:0] event_reg;
	logic wait_done_reg;
	logic acc, wr_ok, sel_ctrl, sel_irq, sel_event;
	logic [31:0] rd_mux;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	assign acc = avs_read || avs_write;
	assign avs_waitrequest = acc && !wait_done_reg;
	assign wr_ok = avs_write && wait_done_reg && avs_byteenable[0];
	assign sel_ctrl = hit(avs_address, CTRL_ADDR);
	assign sel_irq = hit(avs_address, IRQ_CFG_ADDR);
	assign sel_event = hit(avs_address, EVENT_ADDR);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_done_reg <= 1'b0;
		end else begin
			wait_done_reg <= acc && !wait_done_reg;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic auto_en, demand_en;
	logic [2:0] demand_duty;

	assign auto_en = ctrl_reg[CTRL_AUTO_BIT];
	assign demand_en = ctrl_reg[CTRL_DEMAND_BIT];
	// R9: demand duty field
	assign demand_duty = ctrl_reg[CTRL_DUTY_MSB:CTRL_DUTY_LSB];

	// R22: reset clears demand
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RESET;
			irq_cfg_reg <= IRQ_CFG_RESET;
		end else begin
			if (wr_ok && sel_ctrl) begin
				ctrl_reg <= avs_writedata[4:0];
			end
			if (wr_ok && sel_irq) begin
				irq_cfg_reg <= avs_writedata[1:0];
			end
		end
	end

	// ****************************************
	// Hysteresis on hot indication
	// ****************************************
	localparam int HW = $clog2(HYST + 1);
	logic [HW-1:0] cool_reg;
	logic hot_held_reg;
	logic hot_held_next;

	// R7: hold until cool for HYST
	assign hot_held_next = hot_s_reg ? 1'b1 : (cool_reg == HW'(HYST - 1)) ? 1'b0 : hot_held_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cool_reg <= '0;
			hot_held_reg <= 1'b0;
		end else begin
			cool_reg <= (hot_s_reg || !hot_held_reg) ? '0 : cool_reg + 1'b1;
			hot_held_reg <= hot_held_next;
		end
	end

	// R11: alert follows thermal limit
	assign thermal_limit_alert_n = !hot_held_reg;

	// ****************************************
	// Throttle state machine
	// ****************************************
	thr_state_e state_reg, state_next;
	logic auto_act, period_end, mod_active, clk_run;
	logic [2:0] duty_sel;

	// R2: auto only when hot
	assign auto_act = auto_en && hot_held_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			THR_IDLE: begin
				// R8: demand starts at once
				if (auto_act || demand_en) begin
					state_next = THR_RUN;
				end
			end
			THR_RUN: begin
				// R21: demand cleared, end at period
				// R6: cooled, stop
				// R12: held while alert
				if (!auto_act && !demand_en) begin
					state_next = THR_STOP;
				end
			end
			THR_STOP: begin
				if (auto_act || demand_en) begin
					state_next = THR_RUN;
				end else if (period_end) begin
					state_next = THR_IDLE;
				end
			end
			default: state_next = THR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= THR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// R1: modulate while circuit active
	assign mod_active = (state_reg != THR_IDLE) && thermal_trip_n;
	assign clock_throttle_circuit = state_reg != THR_IDLE;
	// R10: auto duty overrides demand
	// R5: fixed constant duty
	// R4: auto duty three eighths
	assign duty_sel = auto_act ? AUTO_DUTY : demand_duty;

	duty_modulator #(
		.SLOTS(SLOTS)
	) u_mod (
		.clk(clk),
		.rstn(rstn),
		.active(mod_active),
		.duty(duty_sel),
		.clk_run(clk_run),
		.period_end(period_end)
	);

	// R14: snoop and interrupt logic stay clocked; only core gated
	assign core_clk_en = clk_run && thermal_trip_n;

	// ****************************************
	// Thermal trip latch
	// ****************************************
	logic trip_reg;

	// R16: catastrophic trip
	// R17: latched until reset
	// R18: no bus side effect
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trip_reg <= 1'b0;
		end else if (crit_s_reg) begin
			trip_reg <= 1'b1;
		end
	end

	assign thermal_trip_n = !trip_reg;
	assign shutdown = trip_reg;

	// ****************************************
	// Alert edge events
	// ****************************************
	logic alert_d_reg, rise_ev, fall_ev;
	logic [1:0] clr;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alert_d_reg <= 1'b0;
		end else begin
			alert_d_reg <= hot_held_reg;
		end
	end

	assign rise_ev = hot_held_reg && !alert_d_reg;
	assign fall_ev = !hot_held_reg && alert_d_reg;
	assign clr = (wr_ok && sel_event) ? avs_writedata[1:0] : 2'h0;

	// R15: sticky events, set beats clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			event_reg <= 2'h0;
		end else begin
			event_reg[IRQ_RISE_BIT] <= rise_ev || (event_reg[IRQ_RISE_BIT] && !clr[IRQ_RISE_BIT]);
			event_reg[IRQ_FALL_BIT] <= fall_ev || (event_reg[IRQ_FALL_BIT] && !clr[IRQ_FALL_BIT]);
		end
	end

	assign thermal_irq = |(event_reg & irq_cfg_reg);

	// ****************************************
	// Read data
	// ****************************************
	// R13: threshold not readable
	assign rd_mux = sel_ctrl ? {27'h0, ctrl_reg} :
		hit(avs_address, STATUS_ADDR) ? {28'h0, trip_reg, hot_held_reg, clock_throttle_circuit, clk_run} :
		sel_irq ? {30'h0, irq_cfg_reg} :
		sel_event ? {30'h0, event_reg} : 32'h0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !wait_done_reg) begin
			avs_readdata <= rd_mux;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_trip_latched;
		@(posedge clk) disable iff (!rstn) !thermal_trip_n |=> !thermal_trip_n;
	endproperty
	a_trip_latched: assert property (p_trip_latched) else $error("trip released"); // R17

	property p_trip_set;
		@(posedge clk) disable iff (!rstn) crit_s_reg |=> !thermal_trip_n && shutdown;
	endproperty
	a_trip_set: assert property (p_trip_set) else $error("trip not asserted"); // R16

	property p_demand_start;
		@(posedge clk) disable iff (!rstn) (demand_en && state_reg == THR_IDLE) |=> clock_throttle_circuit;
	endproperty
	a_demand_start: assert property (p_demand_start) else $error("demand not immediate"); // R8

	property p_alert_holds;
		@(posedge clk) disable iff (!rstn) (auto_en && !thermal_limit_alert_n) |=> clock_throttle_circuit;
	endproperty
	a_alert_holds: assert property (p_alert_holds) else $error("throttle off during alert"); // R12

	property p_auto_duty;
		@(posedge clk) disable iff (!rstn) auto_act |-> duty_sel == AUTO_DUTY;
	endproperty
	a_auto_duty: assert property (p_auto_duty) else $error("auto duty not used"); // R10

	property p_demand_end;
		@(posedge clk) disable iff (!rstn) (state_reg == THR_STOP && !auto_act && !demand_en) |-> ##[1:40] !clock_throttle_circuit;
	endproperty
	a_demand_end: assert property (p_demand_end) else $error("throttle not ended in period"); // R21

	property p_hyst;
		@(posedge clk) disable iff (!rstn) $fell(hot_held_reg) |-> $past(!hot_s_reg, 2);
	endproperty
	a_hyst: assert property (p_hyst) else $error("alert released without cool time"); // R7

	property p_event_rise;
		@(posedge clk) disable iff (!rstn) rise_ev |=> event_reg[IRQ_RISE_BIT];
	endproperty
	a_event_rise: assert property (p_event_rise) else $error("rise event lost"); // R15

	property p_no_auto_cold;
		@(posedge clk) disable iff (!rstn) (state_reg == THR_IDLE && !demand_en && !hot_held_reg) |=> !clock_throttle_circuit;
	endproperty
	a_no_auto_cold: assert property (p_no_auto_cold) else $error("throttle without cause"); // R2

endmodule // thermal_clock_throttle

//--- thermal_board_model.sv
// Board-side model: die temperature source and core supply switch
`timescale 1ns/1ps
module thermal_board_model #(
	parameter int HOT_C = 100, // Near-limit level, plain default
	parameter int TRIP_C = 135 // Catastrophic level
) (
	input wire logic clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire logic [7:0] temp_c, // Die temperature
	input wire logic thermal_trip_n, // Trip from device
	output logic hot_in, // Near-limit flag
	output logic critical_in, // Catastrophic flag
	output logic supply_on // Core supply enable
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hot_in <= 1'b0;
			critical_in <= 1'b0;
			supply_on <= 1'b1;
		end else begin
			hot_in <= (temp_c >= HOT_C);
			critical_in <= (temp_c >= TRIP_C);
			supply_on <= supply_on & thermal_trip_n;
		end
	end
endmodule // thermal_board_model

//--- tb_top.sv
// Self-checking bench for the thermal clock throttle
`timescale 1ns/1ps
module tb_top;
	import thermal_pkg::*;
	localparam int S = 2;
	localparam int H = 8;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] temp_c = 8'h19;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata;
	logic wait_req, clk_en, alert_n, trip_n, shut, irq, thr, hot, crit, supply;
	int fails = 0;
	int num_checks = 0;
	always #2 clk = ~clk;
	thermal_board_model board (.clk(clk), .rstn(rstn), .temp_c(temp_c), .thermal_trip_n(trip_n),
		.hot_in(hot), .critical_in(crit), .supply_on(supply));
	thermal_clock_throttle #(.SLOTS(S), .HYST(H)) uut (.clk(clk), .rstn(rstn), .hot_in(hot),
		.critical_in(crit), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req), .core_clk_en(clk_en),
		.thermal_limit_alert_n(alert_n), .thermal_trip_n(trip_n), .shutdown(shut),
		.thermal_irq(irq), .clock_throttle_circuit(thr));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] b,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		be <= b;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wait_req === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20) begin
			fails++;
			close_out();
		end
	endtask
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, 4'hf, q);
	endtask
	task automatic get(input string name, input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, 4'hf, q);
		chk(name, exp, q);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic count_run(input string name, input int exp);
		int c;
		c = 0;
		repeat (8 * S) begin
			@(negedge clk);
			if (clk_en === 1'b1) c++;
		end
		chk(name, exp, c);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] q;
		get("ctrl", CTRL_ADDR, 32'h0);
		get("irq_cfg", IRQ_CFG_ADDR, 32'h0);
		get("status_idle", STATUS_ADDR, 32'h1);
		chk("pins", 32'h7, {alert_n, trip_n, clk_en});
		chk("throttle", 32'h0, thr);
		put(4'h2, 32'hff);
		bus(CTRL_ADDR, 1'b1, 32'h1f, 4'h0, q);
		get("ctrl_kept", CTRL_ADDR, 32'h0);
	endtask
	task automatic t_demand();
		for (int k = 1; k < 8; k++) begin
			put(CTRL_ADDR, 32'h10 | (k << 1));
			cyc(2);
			chk("throttle_on", 32'h1, thr);
			count_run("demand_duty", k * S);
		end
		put(CTRL_ADDR, 32'h0);
		cyc(8 * S + 2);
		chk("throttle_off", 32'h0, thr);
		chk("clk_free", 32'h1, clk_en);
	endtask
	task automatic t_auto();
		logic [31:0] q;
		put(CTRL_ADDR, 32'h1);
		put(IRQ_CFG_ADDR, 32'h1);
		put(EVENT_ADDR, 32'h3);
		cyc(4);
		chk("cool_idle", 32'h0, thr);
		temp_c <= 8'h6e;
		cyc(6);
		chk("alert", 32'h0, alert_n);
		chk("auto_on", 32'h1, thr);
		chk("irq_rise", 32'h1, irq);
		get("event", EVENT_ADDR, 32'h1);
		put(EVENT_ADDR, 32'h1);
		cyc(1);
		chk("irq_clr", 32'h0, irq);
		// Run bit toggles with the duty; check the steady bits
		bus(STATUS_ADDR, 1'b0, 32'h0, 4'hf, q);
		chk("status_hot", 32'h6, q & 32'he);
		count_run("auto_duty", AUTO_DUTY * S);
		put(CTRL_ADDR, 32'h1f);
		count_run("auto_wins", AUTO_DUTY * S);
		put(CTRL_ADDR, 32'h1);
		temp_c <= 8'h5a;
		cyc(H / 2);
		chk("hyst_hold", 32'h0, alert_n);
		chk("held_on", 32'h1, thr);
		cyc(H + 8 * S + 8);
		chk("alert_off", 32'h1, alert_n);
		chk("auto_off", 32'h0, thr);
		chk("irq_masked", 32'h0, irq);
		get("event_fall", EVENT_ADDR, 32'h2);
		put(EVENT_ADDR, 32'h2);
	endtask
	task automatic t_trip();
		temp_c <= 8'h8c;
		cyc(6);
		chk("trip", 32'h2, {trip_n, shut, clk_en});
		chk("no_bus", 32'h0, wait_req);
		temp_c <= 8'h19;
		cyc(10);
		chk("trip_latched", 32'h0, trip_n);
		chk("supply", 32'h0, supply);
		@(posedge clk);
		rstn <= 1'b0;
		cyc(3);
		chk("trip_reset", 32'h1, trip_n);
		@(posedge clk);
		rstn <= 1'b1;
		get("ctrl_reset", CTRL_ADDR, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_demand();
		t_auto();
		t_trip();
		close_out();
	end
endmodule // tb_top
